/* File: src/igp_gate_protect.sv */
`timescale 1ns/10ps
module igp_gate_protect #(
  parameter int CNT_W = 24
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              drive_in_u_low,
  input  wire logic              drive_in_v_low,
  input  wire logic              drive_in_w_low,
  input  wire logic              drive_in_u_high,
  input  wire logic              drive_in_v_high,
  input  wire logic              drive_in_w_high,
  input  wire logic              ctrl_supply_low_trip,
  input  wire logic [2:0]        boot_supply_low_trip,
  input  wire logic              overcurrent_trip,
  input  wire logic [CNT_W-1:0]  fault_pulse_len_cfg,
  output igp_pkg::igp_gate_s     gate,
  output logic                   fault_out_n_o,
  output logic                   fault_out_n_oe
);

  localparam int NS = 11;
  logic [NS-1:0]       raw;
  logic [NS-1:0]       sync1;
  logic [NS-1:0]       sync2;
  igp_pkg::igp_gate_s  din;
  igp_pkg::igp_gate_s  din_q;
  logic                ctrl_uv;
  logic [2:0]          boot_uv;
  logic                oc;
  logic                ctrl_uv_q;
  logic [2:0]          armed_low;
  logic [2:0]          armed_high;
  logic                fault_active;
  igp_pkg::igp_gate_s  next_gate;

  assign raw = {overcurrent_trip, boot_supply_low_trip, ctrl_supply_low_trip,
                drive_in_w_high, drive_in_v_high, drive_in_u_high,
                drive_in_w_low, drive_in_v_low, drive_in_u_low};

  // Pins come from outside the clock domain and are synchronised.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  assign din.low  = sync2[2:0];
  assign din.high = sync2[5:3];
  assign ctrl_uv  = sync2[6];
  assign boot_uv  = sync2[9:7];
  assign oc       = sync2[10];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      din_q     <= '0;
      ctrl_uv_q <= 1'b1;
    end else begin
      din_q     <= din;
      ctrl_uv_q <= ctrl_uv;
    end
  end

  // Arming: cleared under undervoltage, set by a fresh rising input.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      armed_low  <= igp_pkg::GATE_RESET;
      armed_high <= igp_pkg::GATE_RESET;
    end else begin
      for (int i = 0; i < igp_pkg::PHASES; i++) begin
        if (ctrl_uv) begin
          armed_low[i]  <= 1'b0;
          armed_high[i] <= 1'b0;
        end else if (din.low[i] && !din_q.low[i]) begin
          armed_low[i]  <= 1'b1;
        end
        if (!ctrl_uv) begin
          if (boot_uv[i]) begin
            armed_high[i] <= 1'b0;
          end else if (din.high[i] && !din_q.high[i]) begin
            armed_high[i] <= 1'b1;
          end
        end
      end
    end
  end

  igp_fault_timer #(
    .W (CNT_W)
  ) u_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    ((ctrl_uv && !ctrl_uv_q) || oc),
    .len_cfg  (fault_pulse_len_cfg),
    .active   (fault_active)
  );

  always_comb begin
    for (int i = 0; i < igp_pkg::PHASES; i++) begin
      // Low side blocked by supply, overcurrent and fault pulse.
      next_gate.low[i]  = din.low[i] && armed_low[i] && !ctrl_uv && !oc
                          && !fault_active;
      next_gate.high[i] = din.high[i] && armed_high[i] && !boot_uv[i]
                          && !ctrl_uv;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gate <= '0;
    end else begin
      gate <= next_gate;
    end
  end

  assign fault_out_n_o  = 1'b0;
  assign fault_out_n_oe = fault_active;

  a_uv_low_off: assert property (@(posedge core_clk) disable iff (reset)
    ctrl_uv |=> (gate.low == 3'h0))
    else $error("low gate on during supply undervoltage");
  a_uv_fault: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl_uv && !ctrl_uv_q) |=> fault_out_n_oe)
    else $error("no fault pulse on undervoltage");
  a_oc_gate_off: assert property (@(posedge core_clk) disable iff (reset)
    oc |=> (gate.low == 3'h0))
    else $error("low gate on after overcurrent");
  a_oc_fault: assert property (@(posedge core_clk) disable iff (reset)
    oc |=> fault_out_n_oe)
    else $error("no fault pulse on overcurrent");
  a_pulse_blocks: assert property (@(posedge core_clk) disable iff (reset)
    fault_active |=> (gate.low == 3'h0))
    else $error("low gate on during fault pulse");
  a_boot_no_fault: assert property (@(posedge core_clk) disable iff (reset)
    ($rose(boot_uv[0]) && !ctrl_uv && !oc && !fault_active) |=> !fault_out_n_oe)
    else $error("fault raised by bootstrap undervoltage");
  a_boot_high_off: assert property (@(posedge core_clk) disable iff (reset)
    boot_uv[0] |=> !gate.high[0])
    else $error("high gate on during bootstrap undervoltage");
  a_rearm_edge: assert property (@(posedge core_clk) disable iff (reset)
    ($fell(ctrl_uv) && din.low[0]) |=> !gate.low[0])
    else $error("gate on without a fresh input");
  a_follow_in: assert property (@(posedge core_clk) disable iff (reset)
    (armed_high[1] && !boot_uv[1] && !ctrl_uv) |=> (gate.high[1] == $past(din.high[1])))
    else $error("high gate does not follow input");
  a_fault_drive: assert property (@(posedge core_clk) disable iff (reset)
    fault_out_n_oe |-> !fault_out_n_o)
    else $error("fault output not driven low");

  c_oc_trip: cover property (@(posedge core_clk) disable iff (reset) oc ##1 fault_active);
  c_uv_cycle: cover property (@(posedge core_clk) disable iff (reset)
    $fell(ctrl_uv) ##[1:50] gate.low[0]);
  c_pulse_end: cover property (@(posedge core_clk) disable iff (reset) $fell(fault_active));
  c_boot_recover: cover property (@(posedge core_clk) disable iff (reset)
    $fell(boot_uv[2]) ##[1:50] gate.high[2]);

endmodule

/* File: shared/igp_pkg.sv */
package igp_pkg;

  localparam int  CLK_FREQ_HZ         = 125_000_000;
  // Fault pulse width, shortest and typical, in microseconds.
  localparam int  FAULT_PULSE_MIN_US  = 1000;
  localparam int  FAULT_PULSE_TYP_US  = 1800;
  localparam int  FAULT_PULSE_MIN_CYC = (FAULT_PULSE_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int  FAULT_PULSE_TYP_CYC = (FAULT_PULSE_TYP_US * (CLK_FREQ_HZ / 1_000_000));
  // Leg blanking time the host must keep, in nanoseconds.
  localparam int  LEG_BLANKING_NS     = 2000;
  localparam int  LEG_BLANKING_CYC    = (LEG_BLANKING_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int  PHASES              = 3;
  localparam logic [2:0] GATE_RESET   = 3'h0;

  // Per-phase drive or gate triple, u in bit 0.
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } igp_gate_s;

  typedef enum logic [1:0] {
    IGP_ST_IDLE  = 2'b00,
    IGP_ST_PULSE = 2'b01
  } igp_fault_e;

endpackage

/* File: src/igp_fault_timer.sv */
`timescale 1ns/10ps
module igp_fault_timer #(
  parameter int W = 24
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         start,
  input  wire logic [W-1:0] len_cfg,
  output logic              active
);

  igp_pkg::igp_fault_e state;
  logic [W-1:0]        count;

  // A start restarts the count, so the pulse covers the latest trigger.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= igp_pkg::IGP_ST_IDLE;
      count <= '0;
    end else begin
      case (state)
        igp_pkg::IGP_ST_IDLE: begin
          if (start) begin
            state <= igp_pkg::IGP_ST_PULSE;
            count <= len_cfg;
          end
        end
        igp_pkg::IGP_ST_PULSE: begin
          if (start) begin
            count <= len_cfg;
          end else if (count <= W'(1)) begin
            state <= igp_pkg::IGP_ST_IDLE;
            count <= '0;
          end else begin
            count <= count - W'(1);
          end
        end
        default: begin
          state <= igp_pkg::IGP_ST_IDLE;
          count <= '0;
        end
      endcase
    end
  end

  assign active = (state == igp_pkg::IGP_ST_PULSE);

endmodule

/* File: testbench/igp_host_model.sv */
`timescale 1ns/10ps
module igp_host_model (
  input  wire logic          core_clk,
  input  igp_pkg::igp_gate_s cmd,
  input  wire logic          fault_out_n_o,
  input  wire logic          fault_out_n_oe,
  output igp_pkg::igp_gate_s pins = '0,
  output logic               fault_line
);
  // Pull-up on the open-drain fault line.
  assign fault_line = fault_out_n_oe ? fault_out_n_o : 1'b1;
  // Turn-offs go out at once; turn-ons wait out the leg blanking time.
  always @(cmd) begin
    pins <= pins & cmd;
    repeat (igp_pkg::LEG_BLANKING_CYC) @(negedge core_clk);
    pins <= cmd;
  end
endmodule

/* File: testbench/test_igp_gate_protect.sv */
`timescale 1ns/10ps
module test_igp_gate_protect;
  localparam logic [15:0] LEN = 16'h0258;
  logic               core_clk = 1'b0;
  logic               reset = 1'b1;
  logic               ctrl_uv = 1'b0;
  logic [2:0]         boot_uv = 3'h0;
  logic               oc = 1'b0;
  igp_pkg::igp_gate_s cmd = '0;
  igp_pkg::igp_gate_s pins;
  igp_pkg::igp_gate_s gate;
  logic               fo_o;
  logic               fo_oe;
  logic               fault_line;
  logic [15:0]        low_cnt = 16'h0000;
  int                 fail_count = 0;
  int                 check_count = 0;
  igp_host_model i_igp_host_model (.core_clk(core_clk), .cmd(cmd), .fault_out_n_o(fo_o),
    .fault_out_n_oe(fo_oe), .pins(pins), .fault_line(fault_line));
  igp_gate_protect i_igp_gate_protect (.core_clk(core_clk), .reset(reset),
    .drive_in_u_low(pins.low[0]), .drive_in_v_low(pins.low[1]), .drive_in_w_low(pins.low[2]),
    .drive_in_u_high(pins.high[0]), .drive_in_v_high(pins.high[1]),
    .drive_in_w_high(pins.high[2]), .ctrl_supply_low_trip(ctrl_uv),
    .boot_supply_low_trip(boot_uv), .overcurrent_trip(oc),
    .fault_pulse_len_cfg({8'h00, LEN}), .gate(gate), .fault_out_n_o(fo_o),
    .fault_out_n_oe(fo_oe));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (fault_line === 1'b0) low_cnt <= low_cnt + 16'h0001;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic drive(input logic [5:0] v);
    cmd = v;
    tick(igp_pkg::LEG_BLANKING_CYC + 4);
  endtask
  task automatic wait_clear();
    int n;
    n = 0;
    while (fault_line !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n == 2000) begin
      fail_count++;
      give_verdict();
    end
  endtask
  // Mixed legs: u low on, v and w high on.
  task automatic t_ctrl_uv();
    drive(6'h31);
    check({10'h000, gate}, 16'h0031);
    ctrl_uv = 1'b1;
    tick(4);
    check({10'h000, gate}, 16'h0000);
    check({15'h0000, fault_line}, 16'h0000);
    ctrl_uv = 1'b0;
    tick(4);
    check({10'h000, gate}, 16'h0000);
    wait_clear();
    drive(6'h00);
    drive(6'h31);
    check({10'h000, gate}, 16'h0031);
  endtask
  task automatic t_boot_uv();
    drive(6'h38);
    for (int i = 0; i < 3; i++) begin
      boot_uv = 3'h1 << i;
      tick(4);
      check({10'h000, gate}, {10'h000, ~boot_uv, 3'h0});
      check({15'h0000, fault_line}, 16'h0001);
      boot_uv = 3'h0;
      tick(4);
      check({10'h000, gate}, {10'h000, ~(3'h1 << i), 3'h0});
      drive(6'h00);
      drive(6'h38);
      check({10'h000, gate}, 16'h0038);
    end
  endtask
  task automatic t_overcurrent();
    logic [15:0] base;
    drive(6'h31);
    base = low_cnt;
    oc = 1'b1;
    tick(1);
    oc = 1'b0;
    tick(3);
    check({10'h000, gate}, 16'h0030);
    check({15'h0000, fault_line}, 16'h0000);
    drive(6'h0e);
    check({10'h000, gate}, 16'h0008);
    wait_clear();
    check(low_cnt - base, LEN);
    tick(4);
    check({10'h000, gate}, 16'h000e);
  endtask
  initial begin
    tick(8);
    reset = 1'b0;
    check({10'h000, gate}, 16'h0000);
    check({15'h0000, fault_line}, 16'h0001);
    t_ctrl_uv();
    t_boot_uv();
    t_overcurrent();
    give_verdict();
  end
endmodule
